/* spp_port.sv */
// serial peripheral port core: master/slave shift engine and pin control
`timescale 1ns/100ps
module spp_port
  import spp_pkg::*;
(
  input  wire logic                 i_clock,
  input  wire logic                 i_rst,
  input  wire logic [CTL_WIDTH-1:0] i_serial_port_control,
  input  wire logic [1:0]           i_flag_select,
  input  wire logic                 i_tx_valid,
  input  wire logic [WORD_BITS-1:0] i_tx_data,
  output logic                      o_tx_ready,
  output logic                      o_rx_valid,
  output logic [WORD_BITS-1:0]      o_rx_data,
  output logic                      o_multimaster_error,
  input  wire logic                 i_error_clear,
  output logic                      o_busy,
  input  wire logic                 i_serial_shift_clock,
  output logic                      o_serial_shift_clock,
  output logic                      o_serial_shift_clock_oe,
  input  wire logic                 i_slave_device_select_n,
  input  wire logic                 i_mosi,
  output logic                      o_mosi,
  output logic                      o_mosi_oe,
  input  wire logic                 i_miso,
  output logic                      o_miso,
  output logic                      o_miso_oe,
  output logic [NUM_FLAGS-1:0]      o_flag_select_n,
  output logic [NUM_FLAGS-1:0]      o_flag_oe
);
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_LEAD  = 3'b010,
    ST_TRAIL = 3'b100
  } spp_state_t;

  spp_cfg_t cfg;
  logic [3:0] pins_s;
  logic       sck_s, ss_n_s, sdi_s;
  assign cfg = spp_decode(i_serial_port_control);

  // both data pins are synchronised; the role mux sits after the flops, never ahead of them
  spp_sync #(.W(4)) u_sync (
    .i_clock (i_clock),
    .i_rst   (i_rst),
    .i_async ({i_serial_shift_clock, i_slave_device_select_n, i_miso, i_mosi}),
    .o_sync  (pins_s)
  );
  assign sck_s  = pins_s[3];
  assign ss_n_s = pins_s[2];
  assign sdi_s  = cfg.master ? pins_s[1] : pins_s[0];

  spp_state_t            state_reg, state_next;
  logic [7:0]            div_reg, div_next;
  logic [3:0]            bit_reg, bit_next;
  logic [WORD_BITS-1:0]  tsh_reg, tsh_next;
  logic [WORD_BITS-1:0]  rsh_reg, rsh_next;
  logic [WORD_BITS-1:0]  rx_reg, rx_next;
  logic                  rxv_reg, rxv_next;
  logic                  sck_reg, sck_next;
  logic                  sout_reg, sout_next;
  logic                  err_reg, err_next;
  logic                  sck_prev_reg;
  logic                  ss_prev_reg;
  logic [1:0]            fsel_reg, fsel_next;

  // clock level "leading" edge is the one leaving idle polarity
  logic sck_lead, sck_trail, ss_fall, s_active, m_active;
  assign s_active  = !cfg.master && !ss_n_s;
  assign sck_lead  = s_active && (sck_s != sck_prev_reg) && (sck_s != cfg.pol);
  assign sck_trail = s_active && (sck_s != sck_prev_reg) && (sck_s == cfg.pol);
  assign ss_fall   = ss_prev_reg && !ss_n_s;
  assign m_active  = cfg.master && state_reg != ST_IDLE;
  // one cycle of rest after a word so the select rises between words
  assign o_tx_ready = (state_reg == ST_IDLE) && cfg.master && !err_reg && !rxv_reg;
  assign o_busy     = m_active;

  always_comb begin
    state_next = state_reg;
    div_next   = div_reg;
    bit_next   = bit_reg;
    tsh_next   = tsh_reg;
    rsh_next   = rsh_reg;
    rx_next    = rx_reg;
    rxv_next   = 1'b0;
    sck_next   = cfg.pol;
    sout_next  = sout_reg;
    err_next   = err_reg;
    fsel_next  = fsel_reg;
    if (i_error_clear)
      err_next = 1'b0;
    if (cfg.master && !ss_n_s)
      err_next = 1'b1;
    if (cfg.master) begin
      case (state_reg)
        ST_IDLE: begin
          div_next = '0;
          bit_next = '0;
          if (i_tx_valid && !err_reg) begin
            tsh_next   = i_tx_data;
            fsel_next  = i_flag_select;
            // phase 0 puts the first bit out before the first edge
            sout_next  = i_tx_data[WORD_BITS-1];
            if (cfg.pha)
              sout_next = sout_reg;
            state_next = ST_LEAD;
          end
        end
        ST_LEAD: begin
          sck_next = cfg.pol;
          div_next = div_reg + 8'd1;
          if (div_reg == 8'(HALF_CYCLES - 1)) begin
            div_next   = '0;
            sck_next   = !cfg.pol;
            if (cfg.pha)
              sout_next = tsh_reg[WORD_BITS-1];
            else
              rsh_next = {rsh_reg[WORD_BITS-2:0], sdi_s};
            state_next = ST_TRAIL;
          end
        end
        ST_TRAIL: begin
          sck_next = !cfg.pol;
          div_next = div_reg + 8'd1;
          if (div_reg == 8'(HALF_CYCLES - 1)) begin
            div_next = '0;
            sck_next = cfg.pol;
            bit_next = bit_reg + 4'd1;
            tsh_next = {tsh_reg[WORD_BITS-2:0], 1'b0};
            if (cfg.pha)
              rsh_next = {rsh_reg[WORD_BITS-2:0], sdi_s};
            else
              sout_next = tsh_reg[WORD_BITS-2];
            if (bit_reg == 4'(WORD_BITS - 1)) begin
              rx_next    = cfg.pha ? {rsh_reg[WORD_BITS-2:0], sdi_s} : rsh_reg;
              rxv_next   = 1'b1;
              state_next = ST_IDLE;
            end else begin
              state_next = ST_LEAD;
            end
          end
        end
        default: state_next = ST_IDLE;
      endcase
    end else begin
      state_next = ST_IDLE;
      if (ss_fall) begin
        bit_next  = '0;
        tsh_next  = i_tx_data;
        sout_next = i_tx_data[WORD_BITS-1];
      end
      if (sck_lead) begin
        if (cfg.pha)
          sout_next = tsh_reg[WORD_BITS-1];
        else
          rsh_next = {rsh_reg[WORD_BITS-2:0], sdi_s};
      end
      if (sck_trail) begin
        tsh_next = {tsh_reg[WORD_BITS-2:0], 1'b0};
        if (cfg.pha)
          rsh_next = {rsh_reg[WORD_BITS-2:0], sdi_s};
        else
          sout_next = tsh_reg[WORD_BITS-2];
        bit_next = bit_reg + 4'd1;
        if (bit_reg == 4'(WORD_BITS - 1)) begin
          rx_next  = cfg.pha ? {rsh_reg[WORD_BITS-2:0], sdi_s} : rsh_reg;
          rxv_next = 1'b1;
          bit_next = '0;
          tsh_next = i_tx_data;
        end
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      state_reg    <= ST_IDLE;
      div_reg      <= '0;
      bit_reg      <= '0;
      tsh_reg      <= '0;
      rsh_reg      <= '0;
      rx_reg       <= '0;
      rxv_reg      <= 1'b0;
      sck_reg      <= 1'b0;
      sout_reg     <= 1'b1;
      err_reg      <= 1'b0;
      fsel_reg     <= '0;
      sck_prev_reg <= 1'b1;
      ss_prev_reg  <= 1'b1;
    end else begin
      state_reg    <= state_next;
      div_reg      <= div_next;
      bit_reg      <= bit_next;
      tsh_reg      <= tsh_next;
      rsh_reg      <= rsh_next;
      rx_reg       <= rx_next;
      rxv_reg      <= rxv_next;
      sck_reg      <= sck_next;
      sout_reg     <= sout_next;
      err_reg      <= err_next;
      fsel_reg     <= fsel_next;
      sck_prev_reg <= sck_s;
      ss_prev_reg  <= ss_n_s;
    end
  end

  // pin directions follow the role
  spp_drive_t miso_drv;
  always_comb begin
    miso_drv.o  = sout_reg;
    miso_drv.oe = s_active && !cfg.slave_out_disable;
    if (cfg.open_drain_select) begin
      miso_drv.o  = 1'b0;
      miso_drv.oe = miso_drv.oe && !sout_reg;
    end
  end

  assign o_serial_shift_clock    = sck_reg;
  assign o_serial_shift_clock_oe = cfg.master;
  assign o_mosi    = sout_reg;
  assign o_mosi_oe = cfg.master;
  assign o_miso    = miso_drv.o;
  assign o_miso_oe = miso_drv.oe;
  assign o_rx_valid          = rxv_reg;
  assign o_rx_data           = rx_reg;
  assign o_multimaster_error = err_reg;

  // selected flag pin low for the whole word; slave selects are high idle
  always_comb begin
    o_flag_oe       = cfg.master ? '1 : '0;
    o_flag_select_n = '1;
    // held through the cycle after the last edge so a phase 1 slave still sees its last capture
    if (m_active || (cfg.master && rxv_reg))
      o_flag_select_n[fsel_reg] = 1'b0;
  end

  a_idle_clock_quiet: assert property (@(posedge i_clock) disable iff (i_rst)
    (cfg.master && state_reg == ST_IDLE) |=> sck_reg == $past(cfg.pol))
    else $error("shift clock moved while idle");
  a_error_on_select: assert property (@(posedge i_clock) disable iff (i_rst)
    (cfg.master && !ss_n_s) |=> err_reg)
    else $error("multimaster error not flagged");
  a_slave_out_off: assert property (@(posedge i_clock) disable iff (i_rst)
    cfg.slave_out_disable |-> !o_miso_oe)
    else $error("slave output driven while disabled");
  a_open_drain_low: assert property (@(posedge i_clock) disable iff (i_rst)
    (cfg.open_drain_select && o_miso_oe) |-> !o_miso)
    else $error("open drain drove high");
  a_slave_select_gate: assert property (@(posedge i_clock) disable iff (i_rst)
    (!cfg.master && ss_n_s) |-> !o_miso_oe && !sck_lead)
    else $error("slave responded while deselected");
  a_master_dirs: assert property (@(posedge i_clock) disable iff (i_rst)
    cfg.master |-> o_mosi_oe && o_serial_shift_clock_oe && !o_miso_oe)
    else $error("wrong master pin direction");
  a_select_held: assert property (@(posedge i_clock) disable iff (i_rst)
    m_active |-> o_flag_select_n[fsel_reg] == 1'b0)
    else $error("slave select released mid word");
  a_half_period: assert property (@(posedge i_clock) disable iff (i_rst)
    (state_reg == ST_LEAD && div_reg == '0) |-> ##1 state_reg == ST_LEAD)
    else $error("half period too short");
endmodule // spp_port

/* spp_pkg.sv */
// package for the serial peripheral port: constants, types and control decode
package spp_pkg;
  localparam int unsigned WORD_BITS      = 8;
  localparam int unsigned NUM_FLAGS      = 4;
  localparam int unsigned CLOCK_MHZ      = 100;
  localparam int unsigned HALF_PERIOD_NS = 40;
  localparam int unsigned HALF_CYCLES    = (HALF_PERIOD_NS * CLOCK_MHZ) / 1000;
  localparam int unsigned CTL_WIDTH      = 8;
  localparam int unsigned CTL_POL_BIT    = 0;
  localparam int unsigned CTL_PHA_BIT    = 1;
  localparam int unsigned CTL_MASTER_BIT = 2;
  localparam int unsigned CTL_OPD_BIT    = 4;
  localparam int unsigned CTL_DIS_BIT    = 5;
  localparam logic [7:0]  CTL_RESET      = 8'h00;

  typedef struct packed {
    logic o;
    logic oe;
  } spp_drive_t;

  typedef struct packed {
    logic                 master;
    logic                 pol;
    logic                 pha;
    logic                 open_drain_select;
    logic                 slave_out_disable;
  } spp_cfg_t;

  function automatic spp_cfg_t spp_decode(input logic [CTL_WIDTH-1:0] c);
    spp_cfg_t r;
    r.master            = c[CTL_MASTER_BIT];
    r.pol               = c[CTL_POL_BIT];
    r.pha               = c[CTL_PHA_BIT];
    r.open_drain_select = c[CTL_OPD_BIT];
    r.slave_out_disable = c[CTL_DIS_BIT];
    return r;
  endfunction
endpackage

/* spp_sync.sv */
// two-flop synchroniser for pins entering the core clock domain
`timescale 1ns/100ps
module spp_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         i_clock,
  input  wire logic         i_rst,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] meta_next;
  logic [W-1:0] sync_reg;
  logic [W-1:0] sync_next;

  always_comb begin
    meta_next = i_async;
    sync_next = meta_reg;
  end

  // pins are pulled up, so idle high is the safe reset value
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      meta_reg <= '1;
      sync_reg <= '1;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign o_sync = sync_reg;
endmodule // spp_sync

/* spp_slave_model.sv */
// external slave model that answers the port while it is master
`timescale 1ns/100ps
module spp_slave_model (
  input  wire logic       i_sclk,
  input  wire logic       i_sel_n,
  input  wire logic       i_mosi,
  input  wire logic       i_pol,
  input  wire logic       i_pha,
  input  wire logic [7:0] i_reply,
  output logic            o_miso,
  output logic            o_miso_oe,
  output logic [7:0]      o_rx
);
  logic [7:0] tx_sr;
  logic       act;
  assign act       = i_sclk ^ i_pol;
  assign o_miso_oe = ~i_sel_n;
  initial begin
    tx_sr  = 8'h00;
    o_rx   = 8'h00;
    o_miso = 1'b1;
  end
  // phase 0 shows the first bit at select, phase 1 only on the first edge
  always @(negedge i_sel_n) begin
    tx_sr  = i_pha ? i_reply : {i_reply[6:0], 1'b0};
    o_miso = i_pha ? ~i_reply[7] : i_reply[7];
  end
  // the clock is only received here, never driven
  always @(act) begin
    if (!i_sel_n && (act ^ i_pha)) begin
      o_rx = {o_rx[6:0], i_mosi};
    end else if (!i_sel_n) begin
      o_miso = tx_sr[7];
      tx_sr  = {tx_sr[6:0], 1'b0};
    end
  end
endmodule // spp_slave_model

/* spp_port_tb_top.sv */
// testbench for the serial peripheral port in master and slave roles
`timescale 1ns/100ps
module spp_port_tb_top;
  import spp_pkg::*;
  logic       i_clock;
  logic       i_rst;
  logic [7:0] ctl, tx_data, reply, word, rx_data, m_rx;
  logic [1:0] fs;
  logic       tx_valid, err_clr, sel_n, tb_sclk, tb_mosi, tb_drv, sclk_q, pin_bad;
  logic       tx_ready, rx_valid, mm_err, busy, sclk_o, sclk_oe, mosi_o, mosi_oe;
  logic       miso_o, miso_oe, m_miso, m_oe;
  logic [3:0] flag_n, flag_oe, flag_w;
  wire        sclk_w, mosi_w, miso_w;
  int         mismatches, compares, edges, nrx, n, r0;
  // released lines fall back to their pull-ups
  assign sclk_w = sclk_oe ? sclk_o : (tb_drv ? tb_sclk : 1'b1);
  assign mosi_w = mosi_oe ? mosi_o : (tb_drv ? tb_mosi : 1'b1);
  assign miso_w = miso_oe ? miso_o : (m_oe ? m_miso : 1'b1);
  assign flag_w = flag_n | ~flag_oe;

  spp_port i_spp_port (.i_clock(i_clock), .i_rst(i_rst), .i_serial_port_control(ctl),
    .i_flag_select(fs), .i_tx_valid(tx_valid), .i_tx_data(tx_data), .o_tx_ready(tx_ready),
    .o_rx_valid(rx_valid), .o_rx_data(rx_data), .o_multimaster_error(mm_err),
    .i_error_clear(err_clr), .o_busy(busy), .i_serial_shift_clock(sclk_w),
    .o_serial_shift_clock(sclk_o), .o_serial_shift_clock_oe(sclk_oe),
    .i_slave_device_select_n(sel_n), .i_mosi(mosi_w), .o_mosi(mosi_o), .o_mosi_oe(mosi_oe),
    .i_miso(miso_w), .o_miso(miso_o), .o_miso_oe(miso_oe), .o_flag_select_n(flag_n),
    .o_flag_oe(flag_oe));
  spp_slave_model i_spp_slave_model (.i_sclk(sclk_w), .i_sel_n(flag_w[fs]),
    .i_mosi(mosi_w), .i_pol(ctl[CTL_POL_BIT]), .i_pha(ctl[CTL_PHA_BIT]), .i_reply(reply),
    .o_miso(m_miso), .o_miso_oe(m_oe), .o_rx(m_rx));

  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end
  always @(posedge i_clock) begin
    sclk_q <= sclk_o;
    if (sclk_q !== sclk_o) edges++;
    if (rx_valid === 1'b1) nrx++;
    if (miso_oe && (ctl[2] || ctl[5] || (ctl[4] && miso_o))) pin_bad <= 1'b1;
    if (mosi_oe && !ctl[2]) pin_bad <= 1'b1;
  end

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic test_done;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // one master word; the model answers with rp on the chosen flag select
  task automatic mword(input logic [7:0] c, input logic [1:0] f, input logic [7:0] tx,
                       input logic [7:0] rp);
    @(posedge i_clock);
    ctl <= c;
    fs <= f;
    tx_data <= tx;
    reply <= rp;
    repeat (6) @(posedge i_clock);
    #1 edges = 0;
    chk("tx_ready", 8'h01, {7'h00, tx_ready});
    @(posedge i_clock);
    tx_valid <= 1'b1;
    @(posedge i_clock);
    tx_valid <= 1'b0;
    n = 0;
    #1;
    while (rx_valid !== 1'b1 && n < 200) begin
      chk("flags", ~(8'h01 << f), {4'hf, flag_n});
      @(posedge i_clock);
      #1 n++;
    end
    chk("latency", 8'(16 * HALF_CYCLES), n[7:0]);
    chk("rx_data", rp, rx_data);
    chk("far_rx", tx, m_rx);
    repeat (8) @(posedge i_clock);
    #1;
    chk("edges", 8'h10, edges[7:0]);
    chk("idle_level", {7'h00, c[CTL_POL_BIT]}, {7'h00, sclk_o});
    chk("flags_idle", 8'h0f, {4'h0, flag_n});
  endtask
  // one word with the bench as master at half the link rate (80 ns half period), selected when sel is 0
  task automatic sword(input logic [7:0] c, input logic [7:0] tx, input logic sel);
    @(posedge i_clock);
    ctl <= c;
    tx_data <= tx;
    tb_sclk <= c[CTL_POL_BIT];
    repeat (4) @(posedge i_clock);
    #3 r0 = nrx;
    pin_bad = 1'b0;
    sel_n = sel;
    for (int i = 7; i >= 0; i--) begin
      if (!c[CTL_PHA_BIT]) tb_mosi = ~tx[i];
      #80 tb_sclk = ~c[CTL_POL_BIT];
      if (c[CTL_PHA_BIT]) tb_mosi = ~tx[i];
      else word = {word[6:0], miso_w};
      #80 tb_sclk = c[CTL_POL_BIT];
      if (c[CTL_PHA_BIT]) word = {word[6:0], miso_w};
    end
    #80 sel_n = 1'b1;
    repeat (8) @(posedge i_clock);
    #1;
    chk("rx_count", {7'h00, ~sel}, 8'(nrx - r0));
    if (!sel) chk("rx_data", ~tx, rx_data);
    if (!sel) chk("miso_word", c[CTL_DIS_BIT] ? 8'hff : tx, word);
    chk("pin_drive", 8'h00, {7'h00, pin_bad});
  endtask

  initial begin
    i_rst = 1'b1;
    ctl = CTL_RESET;
    {fs, tx_valid, err_clr, tb_sclk, tb_mosi, tb_drv, pin_bad} = '0;
    {tx_data, reply, word} = '0;
    sel_n = 1'b1;
    sclk_q = 1'b0;
    {mismatches, compares, edges, nrx, n, r0} = '0;
    repeat (2) @(posedge i_clock);
    i_rst <= 1'b0;
    @(posedge i_clock);
    #1;
    chk("reset_pins", 8'h4f, {sclk_o, mosi_o, rx_valid, mm_err, flag_n});
    for (int k = 0; k < 4; k++) mword(8'h04 | 8'(k), 2'(k), 8'ha1 + 8'(k), 8'h96 - 8'(k));
    @(posedge i_clock);
    sel_n <= 1'b0;
    repeat (6) @(posedge i_clock);
    #1;
    chk("mm_error", 8'h01, {7'h00, mm_err});
    chk("tx_ready", 8'h00, {7'h00, tx_ready});
    @(posedge i_clock);
    sel_n <= 1'b1;
    repeat (6) @(posedge i_clock);
    err_clr <= 1'b1;
    @(posedge i_clock);
    err_clr <= 1'b0;
    #1;
    chk("mm_clear", 8'h00, {7'h00, mm_err});
    tb_drv = 1'b1;
    sword(8'h00, 8'hc3, 1'b0);
    sword(8'h10, 8'h5a, 1'b0);
    sword(8'h20, 8'h3c, 1'b0);
    sword(8'h01, 8'h96, 1'b0);
    sword(8'h02, 8'h69, 1'b0);
    sword(8'h03, 8'he7, 1'b0);
    sword(8'h00, 8'h81, 1'b1);
    test_done;
  end
  initial begin
    #500000;
    mismatches++;
    test_done;
  end
endmodule // spp_port_tb_top
